// >>> rtl/interval_timer.sv
// millisecond interval counter of one periodic interrupt
`timescale 1ns/1ps
module interval_timer
    import irq_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // control
    input wire logic ms_tick,
    input wire logic restart,
    input wire logic active,
    input wire logic [15:0] interval_ms,
    // event
    output logic expire
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic next_expire;

    // count milliseconds, wrap to zero at the interval
    always_comb
    begin
        next_count = count;
        next_expire = 1'b0;
        if (restart || !active)
            next_count = 16'h0000;
        else if (ms_tick)
        begin
            if ({1'b0, count} + 17'h00001 >= {1'b0, interval_ms})
            begin
                next_count = 16'h0000;
                next_expire = 1'b1;
            end
            else
                next_count = count + 16'h0001;
        end
    end

    // register count and expiry pulse
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            count <= 16'h0000;
            expire <= 1'b0;
        end
        else
        begin
            count <= next_count;
            expire <= next_expire;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_expire_restarts;
        expire |-> (count == 16'h0000);
    endproperty
    a_expire_restarts: assert property (p_expire_restarts) else $error("count not restarted");

    property p_no_expire_idle;
        !active |=> !expire;
    endproperty
    a_no_expire_idle: assert property (p_no_expire_idle) else $error("expiry while inactive");
endmodule : interval_timer

// >>> rtl/irq_pkg.sv
// constants, register map and types of the timed interrupt and flush/clear block
//
// Operation
// - flush discards queued requests of every selected source, others untouched
// - mask: module 23..19, timed 18..15, edge 14..11, counter 10..5, edge 4..1
// - drop clear resets the dropped flag of each selected source
// - timed interval expiry of an enabled timer starts its handler
// - handler completion returns to the interrupted point of normal execution
// - autorun sets the timed enable on entry to executing mode; read only; the code sets it only where the interval is nonzero
// - entering executing mode loads the 16-bit millisecond interval into the counter
// - enabled timer triggers its handler once every loaded interval, repeatedly
// - interval is readable and writable at run time by the period set operation
// - running flag set while handler executes, cleared when handler finishes
// - read-only enable flag shows whether the timer is enabled
// - one executing and one queued per source; further trigger sets dropped flag
// - hardware and software writes set dropped flag; software reads, writes and clears it
// - queued flag set when handler cannot start, cleared when it starts
// - writing interval zero disables the timer and clears its enable
// - nonzero interval on an idle timer starts timing and sets enable
// - interval change while timing applies at once, count restarts from zero
package irq_pkg;
    // ==========================================
    // source mask layout
    localparam int SRC_W = 24;
    localparam int NUM_TIMERS = 4;
    localparam int TIMER_LSB = 15;
    localparam logic [23:0] SRC_MASK = 24'hfffffe; // bit 0 reserved
    // ==========================================
    // register offsets (byte addresses)
    localparam logic [7:0] FLUSH_OFS = 8'h00;
    localparam logic [7:0] CLEAR_OFS = 8'h04;
    localparam logic [7:0] DONE_OFS = 8'h08;
    localparam logic [7:0] EXEC_OFS = 8'h0c;
    localparam logic [7:0] QUEUED_OFS = 8'h10;
    localparam logic [7:0] DROPPED_OFS = 8'h14;
    localparam logic [7:0] INTERVAL_BASE = 8'h18;
    localparam logic [7:0] INTERVAL_LAST = 8'h24;
    localparam logic [7:0] STATUS_OFS = 8'h28;
    // ==========================================
    // reset values
    localparam logic [15:0] INTERVAL_RST = 16'h0000;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
    // ==========================================
    // timing
    localparam int MS_NS = 1000000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    // ==========================================
    // per source request state, gray along idle, run, run with one queued
    typedef enum logic [1:0] {
        SLOT_IDLE = 2'b00,
        SLOT_RUN = 2'b01,
        SLOT_RUN_QUEUED = 2'b11
    } slot_state_type;
endpackage : irq_pkg

// >>> rtl/irq_slot.sv
// one source: executing request, one queued request and dropped flag
`timescale 1ns/1ps
module irq_slot
    import irq_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // controller side
    slot_if.slot s
);
    slot_state_type state;
    slot_state_type next_state;
    logic dropped;
    logic next_dropped;
    logic e;
    logic q;

    // next request state; new trigger wins over flush, clear and done
    always_comb
    begin
        e = (state != SLOT_IDLE);
        q = (state == SLOT_RUN_QUEUED);
        next_dropped = dropped;
        if (s.drop_wr)
            next_dropped = s.drop_wdata;
        if (s.clear)
            next_dropped = 1'b0;
        if (s.flush)
            q = 1'b0;
        if (s.done)
        begin
            e = q;
            q = 1'b0;
        end
        if (s.trig)
        begin
            if (!e)
                e = 1'b1;
            else if (!q)
                q = 1'b1;
            else
                next_dropped = 1'b1;
        end
        next_state = q ? SLOT_RUN_QUEUED : (e ? SLOT_RUN : SLOT_IDLE);
    end

    // register request state
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state <= SLOT_IDLE;
            dropped <= 1'b0;
        end
        else
        begin
            state <= next_state;
            dropped <= next_dropped;
        end
    end

    assign s.exec = (state != SLOT_IDLE);
    assign s.queued = (state == SLOT_RUN_QUEUED);
    assign s.dropped = dropped;

    // ==========================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_queued_then_done;
        (state == SLOT_RUN_QUEUED) ##1 (state == SLOT_RUN_QUEUED && s.done && !s.flush);
    endsequence

    property p_flush_discards;
        (s.flush && !s.trig) |=> !s.queued;
    endproperty
    a_flush_discards: assert property (p_flush_discards) else $error("flush left queued");

    property p_clear_drop;
        (s.clear && !s.trig) |=> !s.dropped;
    endproperty
    a_clear_drop: assert property (p_clear_drop) else $error("clear left dropped");

    property p_overflow_drops;
        (state == SLOT_RUN_QUEUED && s.trig && !s.done && !s.flush) |=> s.dropped && s.queued;
    endproperty
    a_overflow_drops: assert property (p_overflow_drops) else $error("overflow not dropped");

    property p_queue_starts;
        s_queued_then_done |=> s.exec && (s.queued == $past(s.trig));
    endproperty
    a_queue_starts: assert property (p_queue_starts) else $error("queued request not started");

    property p_idle_starts;
        (state == SLOT_IDLE && s.trig) |=> s.exec && !s.queued;
    endproperty
    a_idle_starts: assert property (p_idle_starts) else $error("trigger did not start handler");
endmodule : irq_slot

// >>> rtl/slot_if.sv
// request/handler signals between the controller and one source slot
`timescale 1ns/1ps
interface slot_if;
    logic trig;
    logic done;
    logic flush;
    logic clear;
    logic drop_wr;
    logic drop_wdata;
    logic exec;
    logic queued;
    logic dropped;
    modport ctrl (output trig, done, flush, clear, drop_wr, drop_wdata,
                  input exec, queued, dropped);
    modport slot (input trig, done, flush, clear, drop_wr, drop_wdata,
                  output exec, queued, dropped);
endinterface : slot_if

// >>> rtl/timed_interrupt_flush_clear.sv
// user interrupt flush/clear and periodic timed interrupts behind an APB slave
`timescale 1ns/1ps
module timed_interrupt_flush_clear
    import irq_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt source pins
    input wire logic [4:0] module_irq,
    input wire logic [7:0] edge_irq,
    input wire logic [5:0] counter_irq,
    // controller mode and stored configuration
    input wire logic run_mode,
    input wire logic [3:0] autorun_flag,
    // handler status
    output logic handler_active,
    output logic [3:0] periodic_irq
);
    // ==========================================
    // decode helpers

    // true for one of the interval words
    function automatic logic ival_hit(input logic [7:0] a);
        return (a >= INTERVAL_BASE) && (a <= INTERVAL_LAST) && (a[1:0] == 2'b00);
    endfunction : ival_hit

    // timer number of an interval word
    function automatic logic [1:0] ival_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - INTERVAL_BASE;
        return d[3:2];
    endfunction : ival_idx

    // true for any word of the map
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == FLUSH_OFS) || (a == CLEAR_OFS) || (a == DONE_OFS) || (a == EXEC_OFS)
            || (a == QUEUED_OFS) || (a == DROPPED_OFS) || (a == STATUS_OFS) || ival_hit(a);
    endfunction : is_mapped

    // ==========================================
    // pin synchronisers and edge detection

    localparam int SYNC_W = SRC_W + 5;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] sy1;
    logic [SYNC_W-1:0] sy2;
    logic [SYNC_W-1:0] sy3;
    logic [SRC_W-1:0] pin_rise;
    logic run_s;
    logic run_rise;
    logic [3:0] auto_s;

    // gather pins in mask order; timed bits come from the timers
    assign raw = {autorun_flag, run_mode, module_irq, 4'h0, edge_irq[7:4], counter_irq,
                  edge_irq[3:0], 1'b0};

    // two stages before use, third stage for rising edges
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            sy1 <= '0;
            sy2 <= '0;
            sy3 <= '0;
        end
        else
        begin
            sy1 <= raw;
            sy2 <= sy1;
            sy3 <= sy2;
        end
    end

    assign pin_rise = sy2[SRC_W-1:0] & ~sy3[SRC_W-1:0] & SRC_MASK;
    assign run_s = sy2[SRC_W];
    assign run_rise = sy2[SRC_W] & ~sy3[SRC_W];
    assign auto_s = sy2[SYNC_W-1:SRC_W+1];

    // ==========================================
    // millisecond time base

    logic [15:0] pre;
    logic [15:0] next_pre;
    logic ms_tick;
    logic next_ms_tick;

    // divide the clock down to one pulse per millisecond
    always_comb
    begin
        next_ms_tick = 1'b0;
        next_pre = pre + 16'h0001;
        if (pre >= 16'(MS_CYCLES_P - 1))
        begin
            next_pre = 16'h0000;
            next_ms_tick = 1'b1;
        end
    end

    // register time base
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            pre <= 16'h0000;
            ms_tick <= 1'b0;
        end
        else
        begin
            pre <= next_pre;
            ms_tick <= next_ms_tick;
        end
    end

    // ==========================================
    // apb access phase

    logic access;
    logic wr_fire;
    logic [1:0] widx;
    logic [SRC_W-1:0] wmask;

    assign access = psel && penable && pready;
    assign wr_fire = access && pwrite;
    assign widx = ival_idx(paddr);
    assign wmask = pwdata[SRC_W-1:0] & SRC_MASK;

    // ==========================================
    // interval and enable state of the periodic interrupts

    logic [15:0] interval [NUM_TIMERS];
    logic [15:0] next_interval [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] enable;
    logic [NUM_TIMERS-1:0] next_enable;
    logic [NUM_TIMERS-1:0] restart;
    logic [NUM_TIMERS-1:0] expire;

    // mode entry reloads; period set writes restart the count
    always_comb
    begin
        for (int i = 0; i < NUM_TIMERS; i++)
        begin
            next_interval[i] = interval[i];
            next_enable[i] = enable[i];
            restart[i] = 1'b0;
            if (run_rise)
            begin
                restart[i] = 1'b1;
                if (auto_s[i] && interval[i] != 16'h0000)
                    next_enable[i] = 1'b1;
            end
            if (wr_fire && ival_hit(paddr) && widx == 2'(i))
            begin
                next_interval[i] = pwdata[15:0];
                restart[i] = 1'b1;
                next_enable[i] = (pwdata[15:0] != 16'h0000);
            end
        end
    end

    // register interval and enable
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
                interval[i] <= INTERVAL_RST;
            enable <= '0;
        end
        else
        begin
            interval <= next_interval;
            enable <= next_enable;
        end
    end

    // one counter per periodic interrupt, counting only in executing mode
    for (genvar t = 0; t < NUM_TIMERS; t++)
    begin : g_timer
        interval_timer u_timer (
            .clock(clock),
            .nrst(nrst),
            .ms_tick(ms_tick),
            .restart(restart[t]),
            .active(enable[t] && run_s && interval[t] != 16'h0000),
            .interval_ms(interval[t]),
            .expire(expire[t])
        );
    end

    // ==========================================
    // per source request slots

    logic [SRC_W-1:0] trig_vec;
    logic [SRC_W-1:0] exec_vec;
    logic [SRC_W-1:0] queued_vec;
    logic [SRC_W-1:0] dropped_vec;

    // timer expiries join the pin events in mask order
    assign trig_vec = pin_rise | {5'h00, expire, 15'h0000};

    assign exec_vec[0] = 1'b0;
    assign queued_vec[0] = 1'b0;
    assign dropped_vec[0] = 1'b0;

    for (genvar g = 1; g < SRC_W; g++)
    begin : g_slot
        slot_if sl ();
        assign sl.trig = trig_vec[g];
        assign sl.done = wr_fire && paddr == DONE_OFS && wmask[g];
        assign sl.flush = wr_fire && paddr == FLUSH_OFS && wmask[g];
        assign sl.clear = wr_fire && paddr == CLEAR_OFS && wmask[g];
        assign sl.drop_wr = wr_fire && paddr == DROPPED_OFS;
        assign sl.drop_wdata = pwdata[g];
        assign exec_vec[g] = sl.exec;
        assign queued_vec[g] = sl.queued;
        assign dropped_vec[g] = sl.dropped;
        irq_slot u_slot (
            .clock(clock),
            .nrst(nrst),
            .s(sl.slot)
        );
    end

    // ==========================================
    // apb answer and status outputs

    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_handler_active;
    logic [3:0] next_periodic_irq;

    // answer one cycle after setup; reads show live block state
    always_comb
    begin
        next_pready = psel && !penable;
        next_pslverr = 1'b0;
        next_prdata = PRDATA_RST;
        if (psel && !penable)
        begin
            next_pslverr = !is_mapped(paddr);
            if (!pwrite)
            begin
                if (paddr == EXEC_OFS)
                    next_prdata = {8'h00, exec_vec};
                else if (paddr == QUEUED_OFS)
                    next_prdata = {8'h00, queued_vec};
                else if (paddr == DROPPED_OFS)
                    next_prdata = {8'h00, dropped_vec};
                else if (ival_hit(paddr))
                    next_prdata = {16'h0000, interval[widx]};
                else if (paddr == STATUS_OFS)
                    next_prdata = {23'h000000, run_s, auto_s, enable};
            end
        end
        next_handler_active = |exec_vec;
        next_periodic_irq = exec_vec[TIMER_LSB+3:TIMER_LSB];
    end

    // register bus answer and status
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            prdata <= PRDATA_RST;
            pready <= 1'b0;
            pslverr <= 1'b0;
            handler_active <= 1'b0;
            periodic_irq <= 4'h0;
        end
        else
        begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            handler_active <= next_handler_active;
            periodic_irq <= next_periodic_irq;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_zero_write;
        wr_fire && ival_hit(paddr) && pwdata[15:0] == 16'h0000;
    endsequence

    property p_zero_disables;
        s_zero_write |=> !enable[$past(widx)];
    endproperty
    a_zero_disables: assert property (p_zero_disables) else $error("zero interval kept enable");

    property p_nonzero_enables;
        (wr_fire && ival_hit(paddr) && pwdata[15:0] != 16'h0000) |=> enable[$past(widx)];
    endproperty
    a_nonzero_enables: assert property (p_nonzero_enables) else $error("interval write no enable");

    property p_autorun;
        (run_rise && auto_s[2] && interval[2] != 16'h0000) |=> enable[2];
    endproperty
    a_autorun: assert property (p_autorun) else $error("autorun did not enable");

    property p_expire_runs;
        (expire[0] && !exec_vec[TIMER_LSB]) |=> exec_vec[TIMER_LSB] ##1 periodic_irq[0];
    endproperty
    a_expire_runs: assert property (p_expire_runs) else $error("expiry did not start handler");

    property p_apb_answer;
        (psel && !penable) |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");
endmodule : timed_interrupt_flush_clear

// >>> testbench/tb.sv
// self-checking bench of the timed interrupt and flush/clear block
`timescale 1ns/1ps
module tb;
    import irq_pkg::*;
    // ==========================================
    // stimulus and observed signals
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [18:0] pins = 19'h0;
    logic run_mode = 1'b0;
    logic [3:0] autorun_flag = 4'he;
    logic handler_active;
    logic [3:0] periodic_irq;
    logic [31:0] rdata;
    logic rerr;
    logic [31:0] acc;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    int t0;
    int t1;
    // ==========================================
    // device, 4 cycles to the millisecond
    timed_interrupt_flush_clear #(.MS_CYCLES_P(4)) timed_interrupt_flush_clear_i (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .module_irq(pins[4:0]),
        .edge_irq(pins[12:5]), .counter_irq(pins[18:13]), .run_mode(run_mode),
        .autorun_flag(autorun_flag), .handler_active(handler_active),
        .periodic_irq(periodic_irq));
    // ==========================================
    // clock, cycle count and hang guard
    always #20 clock = ~clock;
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            report_and_stop();
        end
    end
    // ==========================================
    // shared tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string name, input logic [31:0] expected, input logic [31:0] seen);
        total_checks++;
        if (seen !== expected)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, expected, seen);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge clock);
            n++;
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            chk("pready", 32'h1, 32'h0);
    endtask : apb
    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask : wr
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] expected, input string name);
        apb(1'b0, addr, 32'h0);
        chk(name, expected, rdata);
        chk("rd_err", 32'h0, {31'h0, rerr});
    endtask : rd_chk
    task automatic wait_rise(input int idx, output int t);
        int n;
        n = 0;
        while (periodic_irq[idx] !== 1'b1 && n < 200)
        begin
            @(posedge clock);
            n++;
        end
        t = cyc;
        if (n >= 200)
            chk("irq_rise", 32'h1, 32'h0);
    endtask : wait_rise
    // one rising edge on a source pin
    task automatic pulse(input int k);
        pins[k] <= 1'b1;
        repeat (4) @(posedge clock);
        pins[k] <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : pulse
    function automatic int src_bit(input int k);
        if (k < 5)
            return 19 + k;
        if (k < 9)
            return k - 4;
        if (k < 13)
            return k + 2;
        return k - 8;
    endfunction : src_bit
    // ==========================================
    // scenarios
    task automatic t_reset();
        rd_chk(EXEC_OFS, 32'h0, "exec_rst");
        rd_chk(QUEUED_OFS, 32'h0, "queued_rst");
        rd_chk(DROPPED_OFS, 32'h0, "dropped_rst");
        rd_chk(INTERVAL_BASE, 32'h0, "interval0_rst");
        wr(INTERVAL_BASE + 8'h0c, 32'hffffffff);
        rd_chk(INTERVAL_BASE + 8'h0c, 32'h0000ffff, "interval3");
        rd_chk(STATUS_OFS, 32'h000000e8, "status_en");
        wr(INTERVAL_BASE + 8'h0c, 32'h0);
        wr(STATUS_OFS, 32'h0000000f);
        rd_chk(STATUS_OFS, 32'h000000e0, "status_dis");
        apb(1'b0, 8'h2c, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, rerr});
        chk("unmapped_data", 32'h0, rdata);
        $display("test reset done");
    endtask : t_reset
    task automatic t_map();
        acc = 32'h0;
        for (int k = 0; k < 19; k++)
        begin
            pins[k] <= 1'b1;
            repeat (6) @(posedge clock);
            acc = acc | (32'h1 << src_bit(k));
            rd_chk(EXEC_OFS, acc, "exec_map");
        end
        chk("active", 32'h1, {31'h0, handler_active});
        pins <= 19'h0;
        wr(DONE_OFS, 32'h00ffffff);
        rd_chk(EXEC_OFS, 32'h0, "exec_done");
        chk("idle", 32'h0, {31'h0, handler_active});
        $display("test map done");
    endtask : t_map
    task automatic t_queue();
        repeat (3) pulse(0);
        repeat (2) pulse(13);
        rd_chk(QUEUED_OFS, 32'h00080020, "queued_two");
        rd_chk(DROPPED_OFS, 32'h00080000, "dropped_set");
        wr(FLUSH_OFS, 32'h00080001);
        rd_chk(QUEUED_OFS, 32'h00000020, "queued_flush");
        rd_chk(EXEC_OFS, 32'h00080020, "exec_flush");
        wr(DONE_OFS, 32'h00000020);
        rd_chk(EXEC_OFS, 32'h00080020, "exec_next");
        rd_chk(QUEUED_OFS, 32'h0, "queued_next");
        wr(CLEAR_OFS, 32'h00080000);
        rd_chk(DROPPED_OFS, 32'h0, "dropped_clear");
        wr(DROPPED_OFS, 32'h00400000);
        rd_chk(DROPPED_OFS, 32'h00400000, "dropped_rw");
        wr(DROPPED_OFS, 32'h0);
        wr(DONE_OFS, 32'h00ffffff);
        rd_chk(EXEC_OFS, 32'h0, "exec_end");
        $display("test queue done");
    endtask : t_queue
    task automatic t_reload();
        wr(INTERVAL_BASE + 8'h08, 32'h2);
        repeat (20) @(posedge clock);
        chk("irq2_idle", 32'h0, {31'h0, periodic_irq[2]});
        run_mode <= 1'b1;
        t0 = cyc;
        wait_rise(2, t1);
        chk("reload", 32'h1, {31'h0, (t1 - t0) inside {[5:14]}});
        rd_chk(STATUS_OFS, 32'h000001e4, "status_run");
        wr(INTERVAL_BASE + 8'h08, 32'h0);
        rd_chk(EXEC_OFS, 32'h00020000, "exec_timer2");
        wr(DONE_OFS, 32'h00ffffff);
        wr(DONE_OFS, 32'h00ffffff);
        $display("test reload done");
    endtask : t_reload
    task automatic t_timer();
        wr(INTERVAL_BASE, 32'h2);
        wait_rise(0, t0);
        wr(DONE_OFS, 32'h00008000); // handler ends well inside the period
        repeat (2) @(posedge clock);
        chk("irq0_fall", 32'h0, {31'h0, periodic_irq[0]});
        wait_rise(0, t1);
        chk("period", 32'h8, 32'(t1 - t0));
        repeat (18) @(posedge clock);
        wr(INTERVAL_BASE, 32'h0);
        rd_chk(STATUS_OFS, 32'h000001e0, "status_off");
        rd_chk(QUEUED_OFS, 32'h00008000, "queued_t0");
        rd_chk(DROPPED_OFS, 32'h00008000, "dropped_t0");
        wr(DONE_OFS, 32'h00008000);
        rd_chk(EXEC_OFS, 32'h00008000, "exec_t0");
        rd_chk(QUEUED_OFS, 32'h0, "queued_t0_next");
        wr(DONE_OFS, 32'h00008000);
        wr(INTERVAL_BASE, 32'h4);
        repeat (10) @(posedge clock);
        wr(INTERVAL_BASE, 32'h3);
        t0 = cyc;
        wait_rise(0, t1);
        chk("restart", 32'h1, {31'h0, (t1 - t0) inside {[9:16]}});
        wr(INTERVAL_BASE, 32'h0);
        wr(DONE_OFS, 32'h00008000);
        $display("test timer done");
    endtask : t_timer
    // ==========================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_map();
        t_queue();
        t_reload();
        t_timer();
        report_and_stop();
    end
endmodule : tb
